// *** pkg/uips_pkg.sv ***
// Constants for the UART interrupt priority and status unit.
// Operation
// - Six priority levels, one source reported
// - Read returns highest pending level code
// - No other source reported while pending
// - Read clears only the reported source
// - Line status: level 1, code 000110
// - Rx data 000100, time-out 001100, level 2
// - Tx empty 000010 level 3; modem 000000
// - Xoff or special char: level 5, 010000
// - CTS/RTS change: level 6, code 100000
// - Bits 7:6 show FIFOs enabled, default 0
// - Bits 5:4 only with enhanced bit 4
// - Xoff bit holds until Xon arrives; a clear write also drops it
// - Bits 3:1 encode levels 1 to 4
// - Bit 0 low while interrupt pending
// - FIFO control bit 0 enables both FIFOs
`default_nettype none
package uips_pkg;
	// Number of interrupt sources, index 0 is highest priority
	localparam int unsigned NSRC = 7;
	localparam int unsigned SRC_LS = 0;
	localparam int unsigned SRC_RXD = 1;
	localparam int unsigned SRC_RTO = 2;
	localparam int unsigned SRC_TXE = 3;
	localparam int unsigned SRC_MS = 4;
	localparam int unsigned SRC_XOFF = 5;
	localparam int unsigned SRC_FLOW = 6;
	// Identification codes in bits 5:0, indexed by source
	localparam logic [5:0] CODE_LS = 6'h06;
	localparam logic [5:0] CODE_RXD = 6'h04;
	localparam logic [5:0] CODE_RTO = 6'h0C;
	localparam logic [5:0] CODE_TXE = 6'h02;
	localparam logic [5:0] CODE_MS = 6'h00;
	localparam logic [5:0] CODE_XOFF = 6'h10;
	localparam logic [5:0] CODE_FLOW = 6'h20;
	localparam logic [5:0] CODE_NONE = 6'h01;
	localparam logic [5:0] SRC_CODE [NSRC] = '{CODE_LS, CODE_RXD, CODE_RTO,
		CODE_TXE, CODE_MS, CODE_XOFF, CODE_FLOW};
	// Sources that need the enhanced feature bit
	localparam logic [6:0] ENH_SRC_MASK = 7'h60;
	// Register byte addresses on the bus
	localparam logic [7:0] ADR_IDENT = 8'h00;
	localparam logic [7:0] ADR_FIFO_CTL = 8'h04;
	localparam logic [7:0] ADR_ENH = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0C;
	localparam logic [7:0] ADR_CLEAR = 8'h10;
	localparam logic [7:0] ADR_ENABLE = 8'h14;
	// Field positions
	localparam int unsigned FIFO_EN_BIT = 0;
	localparam int unsigned ENH_EN_BIT = 4;
	// Reset values
	localparam logic [7:0] IDENT_RST = 8'h01;
	localparam logic [7:0] ENH_RST = 8'h00;
	localparam logic [6:0] SRC_RST = 7'h00;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	// Bus slave states
	typedef enum logic [0:0] {
		UIPS_IDLE = 1'b0,
		UIPS_ACK = 1'b1
	} uips_bus_st_t;
endpackage : uips_pkg
`default_nettype wire

// *** core/uips_prio_enc.sv ***
// Priority encoder that picks the highest pending interrupt source.
`default_nettype none
module uips_prio_enc
	import uips_pkg::*;
(
	input wire logic [6:0] req_i,
	output logic hit_o,
	output logic [5:0] code_o,
	output logic [6:0] onehot_o
);
	// Walk from lowest priority up so the highest request wins
	always_comb begin
		hit_o = 1'b0;
		code_o = CODE_NONE;
		onehot_o = SRC_RST;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (req_i[i]) begin
				hit_o = 1'b1;
				code_o = SRC_CODE[i];
				onehot_o = SRC_RST;
				onehot_o[i] = 1'b1;
			end
		end
	end
endmodule // uips_prio_enc
`default_nettype wire

// *** core/uips_wb_slave.sv ***
// Classic Wishbone handshake: takes a request, answers one cycle later.
`default_nettype none
module uips_wb_slave
	import uips_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	output logic rd_o,
	output logic wr_o,
	output logic ack_o
);
	uips_bus_st_t st; // Handshake state
	wire logic take = (st == UIPS_IDLE) && cyc_i && stb_i; // New request
	// Low byte lane carries every register
	assign wr_o = take && we_i && sel_i[0];
	assign rd_o = take && !we_i;
	assign ack_o = (st == UIPS_ACK);
	// Ack stands one cycle; a request still held after it is taken again
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= UIPS_IDLE;
		end else begin
			unique case (st)
				UIPS_IDLE: st <= take ? UIPS_ACK : UIPS_IDLE;
				UIPS_ACK: st <= UIPS_IDLE;
			endcase
		end
	end
endmodule // uips_wb_slave
`default_nettype wire

// *** core/uips_top.sv ***
// Interrupt prioritisation and identification unit of a UART.
//
// Local design decisions: the address map and the Wishbone slave port.
`default_nettype none
module uips_top
	import uips_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Source events, one-cycle pulses
	input wire logic line_status_evt_i,
	input wire logic rx_data_evt_i,
	input wire logic rx_timeout_evt_i,
	input wire logic tx_empty_evt_i,
	input wire logic modem_evt_i,
	input wire logic xoff_evt_i,
	input wire logic xon_evt_i,
	input wire logic flow_evt_i,
	// Outputs to the rest of the UART
	output logic irq_o,
	output logic fifo_en_o,
	output logic enh_en_o
);
	// Bus strobes
	logic bus_rd; // Read taken this cycle
	logic bus_wr; // Write taken this cycle
	logic bus_ack; // Answer cycle
	logic rd_ident_q; // Last answered read was identification

	// Stored state
	logic fifo_en; // FIFO enable control
	logic [7:0] enh; // Enhanced feature register
	logic [6:0] pend; // Sticky pending sources, also status register
	logic [6:0] src_en; // Per-source enable
	logic [6:0] next_pend; // Next value of pend
	logic irq; // Registered interrupt
	logic [31:0] rdata; // Read data register

	// Priority results
	logic hit; // Some source reportable
	logic [5:0] code; // Code of highest source
	logic [6:0] cur_oh; // One-hot of reported source

	uips_wb_slave u_bus (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.sel_i(sel_i),
		.rd_o(bus_rd),
		.wr_o(bus_wr),
		.ack_o(bus_ack)
	);

	// Address decode
	wire logic sel_ident = (adr_i == ADR_IDENT);
	wire logic sel_fcr = (adr_i == ADR_FIFO_CTL);
	wire logic sel_enh = (adr_i == ADR_ENH);
	wire logic sel_stat = (adr_i == ADR_STATUS);
	wire logic sel_clr = (adr_i == ADR_CLEAR);
	wire logic sel_en = (adr_i == ADR_ENABLE);
	wire logic rd_ident = bus_rd && sel_ident;
	wire logic wr_clr = bus_wr && sel_clr;

	// Incoming events in source order
	wire logic [6:0] evt = {flow_evt_i, xoff_evt_i, modem_evt_i, tx_empty_evt_i,
		rx_timeout_evt_i, rx_data_evt_i, line_status_evt_i};

	// Upper sources only take part with the enhanced bit set
	wire logic enh_on = enh[ENH_EN_BIT];
	wire logic [6:0] enh_mask = enh_on ? 7'h7F : ~ENH_SRC_MASK;
	wire logic [6:0] reportable = pend & src_en & enh_mask;

	uips_prio_enc u_enc (
		.req_i(reportable),
		.hit_o(hit),
		.code_o(code),
		.onehot_o(cur_oh)
	);

	// Identification value as software sees it
	wire logic [1:0] fifo_bits = {2{fifo_en}};
	wire logic [5:0] low_bits = hit ? code : CODE_NONE;
	wire logic [7:0] ident_val = {fifo_bits, low_bits};

	// A read clears only the source it reports
	wire logic [6:0] rd_clr = (rd_ident && hit) ? cur_oh : SRC_RST;
	wire logic [6:0] wr_clr_v = wr_clr ? dat_i[6:0] : SRC_RST;

	// Pending flags: set beats any clear in the same cycle
	for (genvar i = 0; i < NSRC; i++) begin : g_pend
		if (i == SRC_XOFF) begin : g_xoff
			// Xoff stays until Xon or a clear write, a read does not drop it
			assign next_pend[i] = evt[i] |
				(pend[i] & !xon_evt_i & !wr_clr_v[i]);
		end else begin : g_norm
			assign next_pend[i] = evt[i] |
				(pend[i] & !rd_clr[i] & !wr_clr_v[i]);
		end
	end

	// Read multiplexer, unmapped words read as zero
	logic [31:0] next_rdata; // Next read data
	always_comb begin
		next_rdata = DATA_ZERO;
		if (sel_ident) begin
			next_rdata[7:0] = ident_val;
		end else if (sel_fcr) begin
			next_rdata[FIFO_EN_BIT] = fifo_en;
		end else if (sel_enh) begin
			next_rdata[7:0] = enh;
		end else if (sel_stat) begin
			next_rdata[6:0] = pend;
		end else if (sel_en) begin
			next_rdata[6:0] = src_en;
		end
	end

	// Sources and interrupt output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend <= SRC_RST;
			irq <= 1'b0;
		end else begin
			pend <= next_pend;
			irq <= |(next_pend & src_en & enh_mask);
		end
	end

	// Control registers written by software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fifo_en <= 1'b0;
			enh <= ENH_RST;
			src_en <= SRC_RST;
		end else if (bus_wr) begin
			if (sel_fcr) begin
				fifo_en <= dat_i[FIFO_EN_BIT];
			end
			if (sel_enh) begin
				enh <= dat_i[7:0];
			end
			if (sel_en) begin
				src_en <= dat_i[6:0];
			end
		end
	end

	// Read data is captured at the taking edge, clear happens at the same edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata <= DATA_ZERO;
			rd_ident_q <= 1'b0;
		end else if (bus_rd) begin
			rdata <= next_rdata;
			rd_ident_q <= sel_ident;
		end
	end

	assign dat_o = rdata;
	assign ack_o = bus_ack;
	assign irq_o = irq;
	assign fifo_en_o = fifo_en;
	assign enh_en_o = enh_on;

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Only one source reported at once
	a_one_reported: assert property ($onehot0(cur_oh))
		else $error("more than one source reported");

	// Line status outranks everything
	a_line_status_top: assert property (reportable[SRC_LS] |-> ident_val[5:0] == 6'h06)
		else $error("line status code wrong");

	// Level 2 codes
	a_rx_codes: assert property (
		(!reportable[SRC_LS] && reportable[SRC_RXD]) |-> ident_val[5:0] == 6'h04)
		else $error("rx data code wrong");
	a_rto_code: assert property (
		(reportable[2:0] == 3'b100) |-> ident_val[5:0] == 6'h0C)
		else $error("rx time-out code wrong");

	// Levels 3 and 4
	a_tx_modem: assert property ((reportable[4:0] == 5'b10000) |-> ident_val[5:0] == 6'h00
		&& hit)
		else $error("modem code wrong");
	a_tx_code: assert property ((reportable[3:0] == 4'b1000) |-> ident_val[5:0] == 6'h02)
		else $error("tx empty code wrong");

	// Levels 5 and 6 need the enhanced bit
	a_xoff_code: assert property ((reportable[5:0] == 6'b100000) |-> ident_val[5:0] == 6'h10)
		else $error("xoff code wrong");
	a_flow_code: assert property ((reportable == 7'b1000000) |-> ident_val[5:0] == 6'h20)
		else $error("flow code wrong");
	a_enh_gate: assert property (!enh_on |-> ident_val[5:4] == 2'b00)
		else $error("enhanced bits shown while disabled");

	// FIFO bits track the enable
	a_fifo_bits: assert property (ident_val[7:6] == {fifo_en, fifo_en})
		else $error("fifo bits disagree with enable");

	// None-pending bit
	a_none_bit: assert property (ident_val[0] == !(|reportable))
		else $error("pending bit wrong");

	// Answer carries the code sampled when the read was taken
	a_read_snapshot: assert property (rd_ident |=> ack_o && dat_o[7:0] == $past(ident_val))
		else $error("read data not the sampled code");

	// Read drops the reported source and nothing else
	a_read_clears: assert property (
		(rd_ident && hit && !cur_oh[SRC_XOFF] && !(|(evt & cur_oh)) && !wr_clr)
		|=> (pend & $past(cur_oh)) == SRC_RST)
		else $error("reported source not cleared");
	// An event or xon in the read cycle may legally change other bits, so leave it out
	a_read_keeps: assert property ((rd_ident && !wr_clr && evt == SRC_RST && !xon_evt_i)
		|=> (pend & ~$past(cur_oh)) == ($past(pend) & ~$past(cur_oh)))
		else $error("read cleared another source");

	// Xoff holds until Xon
	a_xoff_sticky: assert property ((pend[SRC_XOFF] && !xon_evt_i && !wr_clr_v[SRC_XOFF])
		|=> pend[SRC_XOFF])
		else $error("xoff dropped without xon");

	// Interrupt output follows enabled pending
	a_irq_follow: assert property (##1 irq_o == $past(|(next_pend & src_en & enh_mask)))
		else $error("irq does not follow pending");

	// Enable write shows in the FIFO bits next cycle
	a_fifo_write: assert property ((bus_wr && sel_fcr) |=> fifo_en == $past(dat_i[0]))
		else $error("fifo enable not stored");

	// Ack lasts one cycle
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");

	// Main scenarios
	c_read_line: cover property (rd_ident && cur_oh[SRC_LS] ##1 ack_o);
	c_read_two: cover property (rd_ident && reportable[SRC_LS] && reportable[SRC_TXE]
		##[1:20] rd_ident && cur_oh[SRC_TXE]);
	c_xoff_xon: cover property (pend[SRC_XOFF] ##[1:20] !pend[SRC_XOFF]);
	c_irq: cover property ($rose(irq_o));
endmodule // uips_top
`default_nettype wire

// *** test/uips_host.sv ***
// Host processor model: a classic Wishbone master for the status unit.
`default_nettype none
module uips_host (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Bus idle at time zero
	initial begin
		{cyc_o, stb_o, we_o} = 3'h0;
		sel_o = 4'h0;
		adr_o = 8'h00;
		dat_o = 32'h0000_0000;
	end
	// One cycle; entered just after a rising edge, waits for ack without a fixed count
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hf;
		dat_o <= wd;
		// The bench timeout ends a hang here
		do @(posedge clk_i); while (ack_i !== 1'b1);
		rd = dat_i;
		// Released lines show junk, so stale values are never read as valid
		{cyc_o, stb_o} <= 2'h0;
		we_o <= ~w;
		adr_o <= ~a;
		dat_o <= ~wd;
		// Strobe stays low one cycle so the request is not retaken
		@(posedge clk_i);
	endtask
endmodule // uips_host
`default_nettype wire

// *** test/uips_top_test.sv ***
// Self-checking bench for the interrupt priority and status unit.
`default_nettype none
module uips_top_test;
	import uips_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack, irq, fifo_en, enh_en;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd;
	// Event pulses: ls, rxd, rto, txe, modem, xoff, xon, flow
	logic [7:0] ev = 8'h00;
	// Model state: pending, enable, FIFO and enhanced bits
	logic [6:0] m_pend = 7'h00;
	logic [6:0] m_en = 7'h00;
	logic m_fifo = 1'b0;
	logic m_enh = 1'b0;
	logic [31:0] seed = 32'h1756_f9a8;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	// Codes by source, last entry means nothing pending
	logic [5:0] codes [8] = '{6'h06, 6'h04, 6'h0c, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01};
	uips_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.line_status_evt_i(ev[0]), .rx_data_evt_i(ev[1]), .rx_timeout_evt_i(ev[2]),
		.tx_empty_evt_i(ev[3]), .modem_evt_i(ev[4]), .xoff_evt_i(ev[5]), .xon_evt_i(ev[6]),
		.flow_evt_i(ev[7]), .irq_o(irq), .fifo_en_o(fifo_en), .enh_en_o(enh_en));
	uips_host u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
	// 10 MHz clock
	always #50 clk_i = ~clk_i;
	// Hang guard, well above the fewer than 2000 cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			summarize();
		end
	end
	// Xorshift source with a fixed start
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Highest reportable source; levels 5 and 6 need the enhanced bit
	function automatic int top_src();
		for (int i = 0; i < 7; i++) begin
			if (m_pend[i] && m_en[i] && (i < 5 || m_enh)) begin
				return i;
			end
		end
		return 7;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, rd);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		u_host.xfer(1'b0, a, 32'h0000_0000, rd);
		check(rd, exp);
	endtask
	// Read identification; the model retires the reported source, except xoff
	task automatic read_ident();
		int s;
		s = top_src();
		rd_chk(ADR_IDENT, {24'h00_0000, {2{m_fifo}}, codes[s]});
		if (s < 7 && s != 5) begin
			m_pend[s] = 1'b0;
		end
	endtask
	// Pulse events for one cycle, then look at the interrupt line
	task automatic pulse(input logic [7:0] e);
		ev <= e;
		@(posedge clk_i);
		ev <= 8'h00;
		m_pend = m_pend | {e[7], e[5:0]};
		m_pend[5] = m_pend[5] & ~e[6];
		@(posedge clk_i);
		@(negedge clk_i);
		check({31'h0, irq}, {31'h0, top_src() < 7});
		@(posedge clk_i);
	endtask
	task automatic summarize();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		logic [31:0] r;
		logic [7:0] e;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd_chk(ADR_IDENT, 32'h0000_0001);
		rd_chk(ADR_STATUS, 32'h0000_0000);
		rd_chk(ADR_ENABLE, 32'h0000_0000);
		rd_chk(8'hfc, 32'h0000_0000);
		// Identification is read-only: a write must not change it
		wr(ADR_IDENT, 32'h0000_00ff);
		rd_chk(ADR_IDENT, 32'h0000_0001);
		for (int k = 0; k < 80; k++) begin
			r = rnd();
			// New configuration now and then, mostly enabled
			if (k % 8 == 0) begin
				m_en = r[14:8] | r[22:16];
				m_enh = r[4];
				m_fifo = r[0];
				wr(ADR_ENABLE, {25'h0, m_en});
				wr(ADR_ENH, {24'h00_0000, r[7:0]});
				wr(ADR_FIFO_CTL, {31'h0, m_fifo});
				rd_chk(ADR_ENH, {24'h00_0000, r[7:0]});
				rd_chk(ADR_FIFO_CTL, {31'h0, m_fifo});
				check({30'h0, fifo_en, enh_en}, {30'h0, m_fifo, m_enh});
			end
			e = r[31:24];
			e[6] = e[6] & ~e[5];
			pulse(e);
			rd_chk(ADR_STATUS, {25'h0, m_pend});
			// Occasional write-one-to-clear
			if (r[23]) begin
				wr(ADR_CLEAR, {25'h0, r[30:24]});
				m_pend = m_pend & ~r[30:24];
			end
			// A random number of reads lets lower sources pile up behind higher ones
			for (int j = 0; j <= int'(r[2:1]); j++) begin
				read_ident();
			end
		end
		summarize();
	end
endmodule // uips_top_test
`default_nettype wire
